// ==== smsel_pkg.sv ====
// Constants for the SMBus target slave-address selection block.
// Assumes a 7-bit addressed SMBus with byte-wide register access.
package smsel_pkg;

  // Slave addresses, 7 bits
  localparam logic [6:0] ADDR_DEFAULT  = 7'h2E;  // 0101 110b
  localparam logic [6:0] ADDR_SEL_LOW  = 7'h2C;  // 0101 100b
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h2D;  // 0101 101b
  localparam logic [6:0] ADDR_ALERT    = 7'h0C;  // 0001 100b
  localparam logic [6:0] ADDR_GENCALL  = 7'h00;

  // Leading bits compared before the strapped address is latched
  localparam int         LATCH_BITS    = 5;
  localparam logic [4:0] ADDR_HI5      = 5'h0B;  // 01011b

  // Byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;

  // Position of a byte inside a transfer
  localparam logic [1:0] BYTE_ADDR     = 2'h0;
  localparam logic [1:0] BYTE_PTR      = 2'h1;
  localparam logic [1:0] BYTE_DATA     = 2'h2;
  localparam logic [1:0] BYTE_EXTRA    = 2'h3;

  // Bus engine states, Gray along idle-rx-ack-tx
  typedef enum logic [1:0] {
    SMSEL_IDLE = 2'b00,
    SMSEL_RX   = 2'b01,
    SMSEL_ACK  = 2'b11,
    SMSEL_TX   = 2'b10
  } smsel_state_t;

endpackage

// ==== smsel_addr_latch.sv ====
// Strap sampling and slave-address latch for the SMBus target.
// Assumes straps are synchronous to clk and stable at reset release.
`timescale 1ns/1ps

module smsel_addr_latch (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       addr_en_strap,
  input  wire logic       addr_sel_strap,
  input  wire logic       latch_req,
  output logic [6:0]      own_addr,
  output logic            strapped_mode,
  output logic            fan_sense_four_enable,
  output logic            fan_drive_three_enable
);

  logic sampled_reg;
  logic sampled_next;
  logic strapped_reg;
  logic strapped_next;
  logic latched_reg;
  logic latched_next;
  logic sel_reg;
  logic sel_next;
  logic fan_en_reg;
  logic fan_en_next;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    sampled_next  = 1'b1;
    strapped_next = strapped_reg;
    latched_next  = latched_reg;
    sel_next      = sel_reg;
    fan_en_next   = fan_en_reg;
    if (!sampled_reg) begin
      // Strap caught once, on the first edge after release
      strapped_next = ~addr_en_strap;
      fan_en_next   = addr_en_strap;
    end else if (strapped_reg && !latched_reg && latch_req) begin
      latched_next = 1'b1;
      sel_next     = addr_sel_strap;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sampled_reg  <= 1'b0;
      strapped_reg <= 1'b0;
      latched_reg  <= 1'b0;
      sel_reg      <= 1'b0;
      fan_en_reg   <= 1'b0;
    end else begin
      sampled_reg  <= sampled_next;
      strapped_reg <= strapped_next;
      latched_reg  <= latched_next;
      sel_reg      <= sel_next;
      fan_en_reg   <= fan_en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Once latched the select strap is no longer looked at
  logic sel_eff;
  assign sel_eff = latched_reg ? sel_reg : addr_sel_strap;

  always_comb begin
    if (sampled_reg && strapped_reg) begin
      own_addr = sel_eff ? smsel_pkg::ADDR_SEL_HIGH
                         : smsel_pkg::ADDR_SEL_LOW;
    end else begin
      own_addr = smsel_pkg::ADDR_DEFAULT;
    end
  end

  assign strapped_mode          = strapped_reg;
  assign fan_sense_four_enable  = fan_en_reg;
  assign fan_drive_three_enable = fan_en_reg;

endmodule // smsel_addr_latch

// ==== smsel_target.sv ====
// SMBus target port with strapped slave-address selection.
// Assumes scl_in/sda_in are already synchronous to clk and that the
// register file answers reg_rdata before the next SCL falling edge.
`timescale 1ns/1ps

module smsel_target (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_en_strap,
  input  wire logic       addr_sel_strap,
  input  wire logic       irq_output_enable,
  input  wire logic       status_pending,
  output logic            fan_sense_four_enable,
  output logic            fan_drive_three_enable,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);

  logic [6:0] own_addr;
  logic       strapped_mode;
  logic       latch_req;

  smsel_addr_latch u_addr (
    .clk                    (clk),
    .arst_n                 (arst_n),
    .addr_en_strap          (addr_en_strap),
    .addr_sel_strap         (addr_sel_strap),
    .latch_req              (latch_req),
    .own_addr               (own_addr),
    .strapped_mode          (strapped_mode),
    .fan_sense_four_enable  (fan_sense_four_enable),
    .fan_drive_three_enable (fan_drive_three_enable)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus condition detection

  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_in & ~scl_q;
  assign scl_fall  = ~scl_in & scl_q;
  assign bus_start = scl_in & scl_q & sda_q & ~sda_in;
  assign bus_stop  = scl_in & scl_q & ~sda_q & sda_in;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine

  smsel_pkg::smsel_state_t st_reg;
  smsel_pkg::smsel_state_t st_next;
  logic [3:0] bit_reg;
  logic [3:0] bit_next;
  logic [1:0] idx_reg;
  logic [1:0] idx_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       have_reg;
  logic       have_next;
  logic       tx_reg;
  logic       tx_next;
  logic       ara_reg;
  logic       ara_next;
  logic       oe_reg;
  logic       oe_next;
  logic       wr_reg;
  logic       wr_next;
  logic       rd_reg;
  logic       rd_next;

  logic [6:0] rx_addr;
  logic       rx_read;
  logic       own_hit;
  logic       ara_hit;
  logic       hi5_hit;

  assign rx_addr = shift_reg[7:1];
  assign rx_read = shift_reg[0];
  assign hi5_hit = rx_addr[6:7-smsel_pkg::LATCH_BITS] == smsel_pkg::ADDR_HI5;
  // General call never equals any own address, so it falls to no ack
  assign own_hit = (rx_addr == own_addr)
                 && (rx_addr != smsel_pkg::ADDR_GENCALL);
  assign ara_hit = (rx_addr == smsel_pkg::ADDR_ALERT) && rx_read
                 && irq_output_enable && status_pending;
  assign latch_req = (st_reg == smsel_pkg::SMSEL_RX) && scl_fall
                   && (bit_reg == smsel_pkg::BITS_PER_BYTE)
                   && (idx_reg == smsel_pkg::BYTE_ADDR)
                   && strapped_mode && hi5_hit && own_hit;

  always_comb begin
    st_next    = st_reg;
    bit_next   = bit_reg;
    idx_next   = idx_reg;
    shift_next = shift_reg;
    ptr_next   = ptr_reg;
    data_next  = data_reg;
    have_next  = have_reg;
    tx_next    = tx_reg;
    ara_next   = ara_reg;
    oe_next    = oe_reg;
    wr_next    = 1'b0;
    rd_next    = 1'b0;
    if (bus_start) begin
      // Also covers repeated start and the start-then-stop bus reset
      st_next   = smsel_pkg::SMSEL_RX;
      bit_next  = 4'h0;
      idx_next  = smsel_pkg::BYTE_ADDR;
      have_next = 1'b0;
      oe_next   = 1'b0;
    end else if (bus_stop) begin
      // A write lands only after a complete write byte frame
      wr_next   = have_reg;
      have_next = 1'b0;
      oe_next   = 1'b0;
      st_next   = smsel_pkg::SMSEL_IDLE;
    end else begin
      case (st_reg)
        smsel_pkg::SMSEL_IDLE: begin
          oe_next = 1'b0;
        end
        smsel_pkg::SMSEL_RX: begin
          if (scl_rise && bit_reg != smsel_pkg::BITS_PER_BYTE) begin
            shift_next = {shift_reg[6:0], sda_in};
            bit_next   = bit_reg + 4'h1;
          end else if (scl_fall
                       && bit_reg == smsel_pkg::BITS_PER_BYTE) begin
            st_next  = smsel_pkg::SMSEL_ACK;
            oe_next  = 1'b1;
            tx_next  = 1'b0;
            ara_next = 1'b0;
            case (idx_reg)
              smsel_pkg::BYTE_ADDR: begin
                if (own_hit) begin
                  idx_next = smsel_pkg::BYTE_PTR;
                  tx_next  = rx_read;
                  rd_next  = rx_read;
                end else if (ara_hit) begin
                  tx_next  = 1'b1;
                  ara_next = 1'b1;
                end else begin
                  oe_next = 1'b0;
                  st_next = smsel_pkg::SMSEL_IDLE;
                end
              end
              smsel_pkg::BYTE_PTR: begin
                ptr_next = shift_reg;
                idx_next = smsel_pkg::BYTE_DATA;
              end
              smsel_pkg::BYTE_DATA: begin
                data_next = shift_reg;
                have_next = 1'b1;
                idx_next  = smsel_pkg::BYTE_EXTRA;
              end
              default: begin
                // Longer than a write byte: no ack, nothing written
                have_next = 1'b0;
                oe_next   = 1'b0;
                st_next   = smsel_pkg::SMSEL_IDLE;
              end
            endcase
          end
        end
        smsel_pkg::SMSEL_ACK: begin
          if (scl_fall) begin
            bit_next = 4'h0;
            if (tx_reg) begin
              // Alert answer carries own address in the top seven bits
              shift_next = ara_reg ? {own_addr, 1'b1} : reg_rdata;
              oe_next    = ara_reg ? ~own_addr[6] : ~reg_rdata[7];
              st_next    = smsel_pkg::SMSEL_TX;
            end else begin
              oe_next = 1'b0;
              st_next = smsel_pkg::SMSEL_RX;
            end
          end
        end
        smsel_pkg::SMSEL_TX: begin
          if (scl_fall) begin
            if (bit_reg == smsel_pkg::LAST_BIT) begin
              // Single-byte reads only: master ack slot is just released
              oe_next = 1'b0;
              st_next = smsel_pkg::SMSEL_IDLE;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = ~shift_reg[6];
              bit_next   = bit_reg + 4'h1;
            end
          end
        end
        default: begin
          oe_next = 1'b0;
          st_next = smsel_pkg::SMSEL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg    <= smsel_pkg::SMSEL_IDLE;
      bit_reg   <= 4'h0;
      idx_reg   <= smsel_pkg::BYTE_ADDR;
      shift_reg <= 8'h00;
      ptr_reg   <= 8'h00;
      data_reg  <= 8'h00;
      have_reg  <= 1'b0;
      tx_reg    <= 1'b0;
      ara_reg   <= 1'b0;
      oe_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
    end else begin
      st_reg    <= st_next;
      bit_reg   <= bit_next;
      idx_reg   <= idx_next;
      shift_reg <= shift_next;
      ptr_reg   <= ptr_next;
      data_reg  <= data_next;
      have_reg  <= have_next;
      tx_reg    <= tx_next;
      ara_reg   <= ara_next;
      oe_reg    <= oe_next;
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open drain: only ever pulls low
  logic sda_out_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_out_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_out   = sda_out_reg;
  assign sda_oe    = oe_reg;
  assign reg_addr  = ptr_reg;
  assign reg_wdata = data_reg;
  assign reg_wr    = wr_reg;
  assign reg_rd    = rd_reg;

endmodule // smsel_target

// ==== smsel_checker.sv ====
// Concurrent checks on the ports of smsel_target.
// Assumes one clock domain and binding at the foot of this file.
`timescale 1ns/1ps

module smsel_checker (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       addr_en_strap,
  input wire logic       addr_sel_strap,
  input wire logic       irq_output_enable,
  input wire logic       status_pending,
  input wire logic       fan_sense_four_enable,
  input wire logic       fan_drive_three_enable,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Edges since reset release, saturating so it never wraps
  logic [1:0] up_cnt_reg;
  logic [1:0] up_cnt_next;

  always_comb begin
    up_cnt_next = (up_cnt_reg == 2'h3) ? up_cnt_reg : up_cnt_reg + 2'h1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_cnt_reg <= 2'h0;
    end else begin
      up_cnt_reg <= up_cnt_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  sda_never_high_a: assert property (sda_out == 1'h0)
    else $error("sda_out driven high");
  reg_pulse_a: assert property (
    (reg_wr || reg_rd) |=> !(reg_wr || reg_rd))
    else $error("register strobe longer than one cycle");
  oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled while scl high");
  oe_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*3])
    else $error("sda pull too short");
  wr_at_stop_a: assert property (
    reg_wr |-> scl_in && sda_in && !sda_oe)
    else $error("write strobe outside stop");
  rd_at_ack_a: assert property (
    reg_rd |-> sda_oe && !scl_in)
    else $error("read strobe outside address ack");
  fan_pair_a: assert property (
    fan_sense_four_enable == fan_drive_three_enable)
    else $error("fan enables disagree");
  fan_sample_a: assert property (up_cnt_reg == 2'h1 |->
    fan_sense_four_enable == $past(addr_en_strap))
    else $error("fan enable not from sampled strap");
  fan_hold_a: assert property (
    up_cnt_reg >= 2'h2 |-> $stable(fan_sense_four_enable))
    else $error("fan enable changed after sampling");

  cover property (reg_wr);
  cover property (reg_rd);
  cover property (up_cnt_reg == 2'h1 && !addr_en_strap);
endmodule // smsel_checker

bind smsel_target smsel_checker smsel_checker_inst (
  .clk(clk), .arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_en_strap(addr_en_strap),
  .addr_sel_strap(addr_sel_strap), .irq_output_enable(irq_output_enable),
  .status_pending(status_pending),
  .fan_sense_four_enable(fan_sense_four_enable),
  .fan_drive_three_enable(fan_drive_three_enable), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

// ==== smsel_host_model.sv ====
// Behavioural SMBus host driving SCL and its share of SDA.
// Assumes the bench resolves open-drain SDA with a pull-up.
`timescale 1ns/1ps

module smsel_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl = 1'h1;
    sda_drv = 1'h1;
  end

  // Four clocks per phase keeps both SCL phases above two clocks
  task automatic hold();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic bit_x(input logic v, output logic s);
    sda_drv = v;
    hold();
    scl = 1'h1;
    hold();
    s = sda_line;
    scl = 1'h0;
    hold();
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic start_c();
    sda_drv = 1'h1;
    hold();
    scl = 1'h1;
    hold();
    sda_drv = 1'h0;
    hold();
    scl = 1'h0;
    hold();
  endtask

  task automatic stop_c();
    sda_drv = 1'h0;
    hold();
    scl = 1'h1;
    hold();
    sda_drv = 1'h1;
    hold();
  endtask

  // Whole bytes only, MSB first, then the ninth clock for the ack
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'h1, s);
    ack = !s;
  endtask

  // Single-byte reads always end with a not-acknowledge
  task automatic recv_byte(output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'h1, d[i]);
    bit_x(1'h1, s);
  endtask
endmodule // smsel_host_model

// ==== smsel_target_bench.sv ====
// Self-checking bench for smsel_target with a behavioural SMBus host.
// Assumes smsel_pkg, the host model and the checker are compiled first.
`timescale 1ns/1ps

`define check_eq(g, e) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("wrong value at %0t: got %h expected %h", \
  $time, g, e); end end

module smsel_target_bench;
  logic        clk;
  logic        arst_n;
  logic        addr_en_strap;
  logic        addr_sel_strap;
  logic        irq_output_enable;
  logic        status_pending;
  logic [7:0]  reg_rdata;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe;
  logic        fan_sense_four_enable;
  logic        fan_drive_three_enable;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        ara_on;
  logic [31:0] seed;
  logic [16:0] expq[$];
  logic [16:0] exp_note;
  int          mismatches;
  int          total_checks;
  // Pull-up on SDA; the device can only win by driving its data level low
  wire logic   sda_line = sda_drv & ~(sda_oe & ~sda_out);

  smsel_target smsel_target_inst (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_en_strap(addr_en_strap),
    .addr_sel_strap(addr_sel_strap), .irq_output_enable(irq_output_enable),
    .status_pending(status_pending),
    .fan_sense_four_enable(fan_sense_four_enable),
    .fan_drive_three_enable(fan_drive_three_enable), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  smsel_host_model smsel_host_model_inst (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction

  task automatic boot(input logic en, input logic sel);
    arst_n = 1'h0;
    addr_en_strap = en;
    addr_sel_strap = sel;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'h1;
    repeat (3) @(posedge clk);
    #1;
    `check_eq(fan_sense_four_enable, en)
    `check_eq(fan_drive_three_enable, en)
  endtask

  // Write byte, or read byte with repeated start; p and d are random
  task automatic xfer(input logic [6:0] a, input logic rd, input logic exp);
    logic ack;
    logic [7:0] p, d, r;
    p = rnd();
    d = rnd();
    reg_rdata = rnd();
    smsel_host_model_inst.start_c();
    smsel_host_model_inst.send_byte({a, 1'h0}, ack);
    `check_eq(ack, exp)
    if (ack) begin
      smsel_host_model_inst.send_byte(p, ack);
      expq.push_back({rd, p, rd ? 8'h00 : d});
      if (rd) begin
        smsel_host_model_inst.start_c();
        smsel_host_model_inst.send_byte({a, 1'h1}, ack);
        smsel_host_model_inst.recv_byte(r);
        `check_eq(r, reg_rdata)
      end else begin
        smsel_host_model_inst.send_byte(d, ack);
      end
    end
    smsel_host_model_inst.stop_c();
  endtask

  task automatic ara(input logic en, input logic pend, input logic [6:0] own);
    logic ack;
    logic [7:0] r;
    irq_output_enable = en;
    status_pending = pend;
    ara_on = 1'h1;
    smsel_host_model_inst.start_c();
    smsel_host_model_inst.send_byte({smsel_pkg::ADDR_ALERT, 1'h1}, ack);
    `check_eq(ack, en & pend)
    if (ack) begin
      smsel_host_model_inst.recv_byte(r);
      `check_eq(r, {own, 1'h1})
    end
    smsel_host_model_inst.stop_c();
    ara_on = 1'h0;
  endtask

  // Note taken once; a strobe with nothing queued meets an impossible note
  always @(negedge clk) begin
    if (reg_wr || (reg_rd && !ara_on)) begin
      exp_note = (expq.size() > 0) ? expq.pop_front() : 17'h1FFFF;
      `check_eq({reg_rd, reg_addr, reg_rd ? 8'h00 : reg_wdata}, exp_note)
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, addr_en_strap, addr_sel_strap, ara_on} = 4'h0;
    {irq_output_enable, status_pending, reg_rdata} = 10'h000;
    {mismatches, total_checks, seed} = {32'h0, 32'h0, 32'h29A5};
    #1;
    boot(1'h1, 1'h0);
    xfer(smsel_pkg::ADDR_DEFAULT, 1'h0, 1'h1);
    xfer(smsel_pkg::ADDR_DEFAULT, 1'h1, 1'h1);
    xfer(smsel_pkg::ADDR_SEL_LOW, 1'h0, 1'h0);
    xfer(smsel_pkg::ADDR_GENCALL, 1'h0, 1'h0);
    ara(1'h0, 1'h1, smsel_pkg::ADDR_DEFAULT);
    ara(1'h1, 1'h0, smsel_pkg::ADDR_DEFAULT);
    ara(1'h1, 1'h1, smsel_pkg::ADDR_DEFAULT);
    $display("test 1 done");
    boot(1'h0, 1'h1);
    xfer(smsel_pkg::ADDR_SEL_HIGH, 1'h1, 1'h1);
    xfer(smsel_pkg::ADDR_DEFAULT, 1'h0, 1'h0);
    ara(1'h1, 1'h1, smsel_pkg::ADDR_SEL_HIGH);
    $display("test 2 done");
    boot(1'h0, 1'h0);
    #8 addr_sel_strap = 1'h1;
    xfer(smsel_pkg::ADDR_SEL_HIGH, 1'h0, 1'h1);
    addr_sel_strap = 1'h0;
    xfer(smsel_pkg::ADDR_SEL_LOW, 1'h0, 1'h0);
    xfer(smsel_pkg::ADDR_SEL_HIGH, 1'h1, 1'h1);
    $display("test 3 done");
    boot(1'h0, 1'h0);
    xfer(smsel_pkg::ADDR_SEL_LOW, 1'h1, 1'h1);
    addr_sel_strap = 1'h1;
    xfer(smsel_pkg::ADDR_SEL_HIGH, 1'h0, 1'h0);
    ara(1'h1, 1'h1, smsel_pkg::ADDR_SEL_LOW);
    $display("test 4 done");
    end_of_test();
  end
endmodule // smsel_target_bench
